// ---- design/status_pkg.sv ----
// Package with the constants, register map and state type of the status block.
`default_nettype none
package status_pkg;
   localparam int REG_W = 16;
   localparam int ADDR_W = 6;
   localparam int CODE_W = 16;
   localparam int MSG_W = 16;
   localparam int QDEPTH = 8;
   localparam int QPTR_W = 3;
   localparam int QCNT_W = 4;
   localparam int FILT_W = 8;
   localparam int NGRP = 3;
   // Group indices: measurement, operation, questionable.
   localparam logic [1:0] GRP_MEAS = 2'h0;
   localparam logic [1:0] GRP_OPER = 2'h1;
   localparam logic [1:0] GRP_QUES = 2'h2;
   // Register offsets of one group; group base is index times GRP_STRIDE.
   localparam logic [ADDR_W-1:0] GRP_STRIDE = 6'h04;
   localparam logic [1:0] SUB_EVENT = 2'h0;
   localparam logic [1:0] SUB_ENABLE = 2'h1;
   localparam logic [1:0] SUB_COND = 2'h2;
   // Command, format, queue and interrupt registers.
   localparam logic [ADDR_W-1:0] ADR_CMD = 6'h10;
   localparam logic [ADDR_W-1:0] ADR_FORMAT = 6'h11;
   localparam logic [ADDR_W-1:0] ADR_QNEXT = 6'h12;
   localparam logic [ADDR_W-1:0] ADR_QMSG = 6'h13;
   localparam logic [ADDR_W-1:0] ADR_QCOUNT = 6'h14;
   localparam logic [ADDR_W-1:0] ADR_QALL = 6'h15;
   localparam logic [ADDR_W-1:0] ADR_FILTER = 6'h16;
   localparam logic [ADDR_W-1:0] ADR_NUMFMT = 6'h17;
   localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 6'h18;
   localparam logic [ADDR_W-1:0] ADR_IRQ_CLR = 6'h19;
   localparam logic [ADDR_W-1:0] ADR_IRQ_EN = 6'h1A;
   // Command register bits, each a one-shot action.
   localparam int CMD_CLS = 0;
   localparam int CMD_STPRESET = 1;
   localparam int CMD_RST = 2;
   localparam int CMD_SYSPRESET = 3;
   localparam int CMD_QCLEAR = 4;
   // Number notation of enable writes and query replies.
   localparam logic [1:0] FMT_DEC = 2'h0;
   localparam logic [1:0] FMT_HEX = 2'h1;
   localparam logic [1:0] FMT_OCT = 2'h2;
   localparam logic [1:0] FMT_BIN = 2'h3;
   // Interrupt bits: three summaries, queue not empty, queue overflow.
   localparam int IRQ_W = 5;
   localparam int IRQ_QNE = 3;
   localparam int IRQ_OVF = 4;
   localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
   localparam logic [FILT_W-1:0] FILT_ALL = 8'hFF;

   typedef enum logic [2:0] {
      Q_IDLE = 3'b001,
      Q_ALL = 3'b010,
      Q_DONE = 3'b100
   } qstate_e;

   typedef struct packed {
      logic [NGRP-1:0][REG_W-1:0] event_r;
      logic [NGRP-1:0][REG_W-1:0] enable_r;
      logic [NGRP-1:0][REG_W-1:0] condSync1;
      logic [NGRP-1:0][REG_W-1:0] condSync2;
      logic [NGRP-1:0][REG_W-1:0] condPrev;
      logic [NGRP-1:0] summary_r;
      logic [QDEPTH-1:0][CODE_W-1:0] qCode;
      logic [QDEPTH-1:0][MSG_W-1:0] qMsg;
      logic [QPTR_W-1:0] qHead;
      logic [QPTR_W-1:0] qTail;
      logic [QCNT_W-1:0] qCount;
      logic [CODE_W-1:0] lastMsg;
      logic [FILT_W-1:0] filter_r;
      logic [1:0] format_r;
      logic [1:0] numFmt_r;
      logic [IRQ_W-1:0] irqStat_r;
      logic [IRQ_W-1:0] irqEn_r;
      logic irq_r;
      logic [REG_W-1:0] rdData_r;
      qstate_e qState;
   } state_s;
endpackage
`default_nettype wire

// ---- design/status_event_and_error_queue.sv ----
// Status register groups, number formatting and error queue of the instrument.
// What this block does
// - Three groups, measurement, operation, questionable, each with event, enable, condition.
// - Condition reads return live condition bits without latching or changing them.
// - Power-up and clear-status clear all event bits; status preset keeps them.
// - Power-up and status preset clear all enable bits; clear-status keeps them.
// - Enable writes accept decimal, hexadecimal, octal or binary notation.
// - Event, enable and condition query replies use the currently selected number format.
// - General reset and system preset leave status registers and settings unchanged.
// - Status preset returns status registers to their defaults per the clear rules.
// - Power-up and clear-status empty the error queue.
// - General reset, system preset, status preset leave the error queue alone.
// - Read-next returns oldest entry code alone, keeps its message for ADR_QMSG, and removes it.
// - Read-all returns one entry per read, oldest first, until the queue is empty.
// - Code-only reads return codes alone and still remove entries.
// - Count read returns the number of queued entries, removing none.
// - Queue-clear command discards every queued entry.
// - Enable and disable classes of codes by their low three bits; disabled codes never enter the queue.
`default_nettype none
module status_event_and_error_queue
   import status_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [status_pkg::ADDR_W-1:0] addr,
   input wire logic [status_pkg::REG_W-1:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [status_pkg::REG_W-1:0] rdData,
   // Live instrument conditions, asynchronous to clk.
   input wire logic [status_pkg::REG_W-1:0] condMeas,
   input wire logic [status_pkg::REG_W-1:0] condOper,
   input wire logic [status_pkg::REG_W-1:0] condQues,
   // Message source: code, message index and push pulse.
   input wire logic [status_pkg::CODE_W-1:0] msgCode,
   input wire logic [status_pkg::MSG_W-1:0] msgText,
   input wire logic msgPush,
   // Group summaries and interrupt.
   output logic [status_pkg::NGRP-1:0] summary,
   output logic irq
);
   import status_pkg::*;

   state_s s;
   state_s n;

   // Parse a value written in the selected notation; digit nibbles carry decimal.
   function automatic logic [REG_W-1:0] parseNum(input logic [1:0] fmt,
                                                 input logic [REG_W-1:0] v);
      logic [REG_W-1:0] r;
      r = REG_ZERO;
      case (fmt)
         FMT_DEC: r = REG_W'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
         FMT_OCT: r = REG_W'(v[14:12] * 512 + v[10:8] * 64 + v[6:4] * 8 + v[2:0]);
         default: r = v;
      endcase
      return r;
   endfunction

   // Render a value for a reply; decimal gives BCD, octal gives 3-bit digits in nibbles.
   function automatic logic [REG_W-1:0] renderNum(input logic [1:0] fmt,
                                                  input logic [REG_W-1:0] v);
      logic [REG_W-1:0] r;
      logic [REG_W-1:0] t;
      r = REG_ZERO;
      t = v % 16'h2710;
      case (fmt)
         FMT_DEC: r = {4'(t / 1000), 4'((t / 100) % 10), 4'((t / 10) % 10), 4'(t % 10)};
         FMT_OCT: r = {1'b0, v[11:9], 1'b0, v[8:6], 1'b0, v[5:3], 1'b0, v[2:0]};
         default: r = v;
      endcase
      return r;
   endfunction

   // Message filter: the low code bits select a class; cleared class means disabled.
   function automatic logic codeAllowed(input logic [FILT_W-1:0] f,
                                        input logic [CODE_W-1:0] c);
      return f[c[2:0]];
   endfunction

   // Next-state logic for every register of the block.
   always_comb begin
      logic cls;
      logic stp;
      logic qclr;
      logic pop;
      logic push;
      logic [1:0] grp;
      logic [1:0] sub;
      logic [REG_W-1:0] rv;
      n = s;
      cls = wrStb && addr == ADR_CMD && wrData[CMD_CLS];
      stp = wrStb && addr == ADR_CMD && wrData[CMD_STPRESET];
      // General reset and system preset bits decode to nothing here.
      qclr = wrStb && addr == ADR_CMD && wrData[CMD_QCLEAR];
      pop = 1'b0;
      grp = addr[3:2];
      sub = addr[1:0];
      rv = REG_ZERO;
      n.condSync1 = {condQues, condOper, condMeas};
      n.condSync2 = s.condSync1;
      n.condPrev = s.condSync2;
      // Events latch on a rising condition; a clear in the same cycle loses.
      for (int g = 0; g < NGRP; g++) begin
         logic [REG_W-1:0] rise;
         rise = s.condSync2[g] & ~s.condPrev[g];
         n.event_r[g] = (cls ? REG_ZERO : s.event_r[g]) | rise;
         if (stp) begin
            n.enable_r[g] = REG_ZERO;
         end
         n.summary_r[g] = |(n.event_r[g] & n.enable_r[g]);
      end
      // Register writes.
      if (wrStb) begin
         if (addr < ADR_CMD && grp != 2'h3 && sub == SUB_ENABLE && !stp) begin
            n.enable_r[grp] = parseNum(s.numFmt_r, wrData);
         end
         case (addr)
            ADR_FORMAT: n.format_r = wrData[1:0];
            ADR_NUMFMT: n.numFmt_r = wrData[1:0];
            ADR_FILTER: n.filter_r = wrData[FILT_W-1:0];
            ADR_IRQ_EN: n.irqEn_r = wrData[IRQ_W-1:0];
            default: ;
         endcase
      end
      // Register reads; replies stand one cycle after the strobe.
      if (rdStb) begin
         if (addr < ADR_CMD && grp != 2'h3) begin
            case (sub)
               SUB_EVENT: rv = renderNum(s.format_r, s.event_r[grp]);
               SUB_ENABLE: rv = renderNum(s.format_r, s.enable_r[grp]);
               SUB_COND: rv = renderNum(s.format_r, s.condSync2[grp]);
               default: rv = REG_ZERO;
            endcase
         end else begin
            case (addr)
               ADR_FORMAT: rv = REG_W'(s.format_r);
               ADR_NUMFMT: rv = REG_W'(s.numFmt_r);
               ADR_FILTER: rv = REG_W'(s.filter_r);
               ADR_IRQ_STAT: rv = REG_W'(s.irqStat_r);
               ADR_IRQ_EN: rv = REG_W'(s.irqEn_r);
               ADR_QCOUNT: rv = REG_W'(s.qCount);
               ADR_QMSG: rv = s.lastMsg;
               ADR_QNEXT, ADR_QALL: begin
                  // Code-only reads use this port; the message is kept for ADR_QMSG.
                  if (s.qCount != '0) begin
                     rv = s.qCode[s.qHead];
                     n.lastMsg = s.qMsg[s.qHead];
                     pop = 1'b1;
                  end
                  if (addr == ADR_QALL) begin
                     n.qState = Q_ALL;
                  end
               end
               default: rv = REG_ZERO;
            endcase
         end
      end
      n.rdData_r = rv;
      // Read-all keeps draining one entry per read until the queue is empty.
      case (s.qState)
         Q_IDLE: ;
         Q_ALL: begin
            if (s.qCount == '0 || (s.qCount == QCNT_W'(1) && pop)) begin
               n.qState = Q_DONE;
            end
         end
         Q_DONE: n.qState = Q_IDLE;
         default: n.qState = Q_IDLE;
      endcase
      // Queue update; a full queue drops new messages and flags an overflow.
      push = msgPush && codeAllowed(s.filter_r, msgCode);
      if (pop) begin
         n.qHead = s.qHead + QPTR_W'(1);
      end
      if (push && (s.qCount != QCNT_W'(QDEPTH) || pop)) begin
         n.qCode[s.qTail] = msgCode;
         n.qMsg[s.qTail] = msgText;
         n.qTail = s.qTail + QPTR_W'(1);
      end
      n.qCount = s.qCount + QCNT_W'(n.qTail != s.qTail) - QCNT_W'(pop);
      // Status preset, general reset and system preset never touch the queue.
      if (cls || qclr) begin
         n.qHead = '0;
         n.qTail = '0;
         n.qCount = '0;
         n.qState = Q_IDLE;
      end
      // Interrupt status: set beats the clear in the same cycle.
      if (wrStb && addr == ADR_IRQ_CLR) begin
         n.irqStat_r = s.irqStat_r & ~wrData[IRQ_W-1:0];
      end
      n.irqStat_r[NGRP-1:0] = n.irqStat_r[NGRP-1:0] | (n.summary_r & ~s.summary_r);
      n.irqStat_r[IRQ_QNE] = n.irqStat_r[IRQ_QNE] | (n.qCount != '0 && s.qCount == '0);
      n.irqStat_r[IRQ_OVF] = n.irqStat_r[IRQ_OVF]
                           | (push && s.qCount == QCNT_W'(QDEPTH) && !pop);
      n.irq_r = |(n.irqStat_r & n.irqEn_r);
   end

   // State register; reset stands for power-up.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.filter_r <= FILT_ALL;
         s.qState <= Q_IDLE;
      end else begin
         s <= n;
      end
   end

   assign rdData = s.rdData_r;
   assign summary = s.summary_r;
   assign irq = s.irq_r;
endmodule
`default_nettype wire

// ---- verification/status_checker.sv ----
// Concurrent checks on the ports of the status block.
`default_nettype none
module status_checker
   import status_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [status_pkg::ADDR_W-1:0] addr,
   input wire logic [status_pkg::REG_W-1:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [status_pkg::REG_W-1:0] rdData,
   // Summaries and interrupt.
   input wire logic [status_pkg::NGRP-1:0] summary,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cmdWr;
   logic grpRd;
   // Decoded strobes; the gap bound covers the idle cycle the host leaves between accesses.
   assign cmdWr = wrStb && addr == ADR_CMD;
   assign grpRd = rdStb && addr < ADR_CMD;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Read answers, command clears and masking; answers and masking at a fixed cycle, clears within a cycle window.
   chk_rd_idle: assert property (!$past(rdStb) |-> rdData == REG_ZERO)
      else $error("read data seen outside the answer cycle");
   chk_unmapped_rd: assert property (rdStb && addr > ADR_IRQ_EN |=> rdData == REG_ZERO)
      else $error("unmapped read returned nonzero");
   chk_cls_event: assert property (
      cmdWr && wrData[CMD_CLS] ##[1:4] (grpRd && addr[1:0] == SUB_EVENT) |=> rdData == REG_ZERO)
      else $error("event bits survived clear-status");
   chk_cls_queue: assert property (
      cmdWr && wrData[CMD_CLS] ##[1:2] (rdStb && addr == ADR_QCOUNT) |=> rdData == REG_ZERO)
      else $error("queue not empty after clear-status");
   chk_qclear_empty: assert property (
      cmdWr && wrData[CMD_QCLEAR] ##[1:2] (rdStb && addr == ADR_QCOUNT) |=> rdData == REG_ZERO)
      else $error("queue not empty after queue clear");
   chk_preset_enable: assert property (
      cmdWr && wrData[CMD_STPRESET] ##[1:2] (grpRd && addr[1:0] == SUB_ENABLE)
      |=> rdData == REG_ZERO)
      else $error("enable bits survived status preset");
   chk_preset_summary: assert property (
      cmdWr && wrData[CMD_STPRESET] |-> ##2 summary == 3'h0)
      else $error("summary high with all enables cleared");
   chk_irq_mask: assert property (wrStb && addr == ADR_IRQ_EN && wrData == REG_ZERO |-> ##2 !irq)
      else $error("interrupt high while fully masked");
endmodule
`default_nettype wire

// ---- verification/msg_source.sv ----
// Model of the instrument side that raises messages toward the status block.
`default_nettype none
module msg_source
   import status_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Request from the bench.
   input wire logic fire,
   input wire logic [status_pkg::CODE_W-1:0] fireCode,
   // Message lines toward the block.
   output logic [status_pkg::CODE_W-1:0] msgCode,
   output logic [status_pkg::MSG_W-1:0] msgText,
   output logic msgPush
);
   timeunit 1ns;
   timeprecision 1ps;
   // Outside a push the lines toggle, so a stale code can never pass for a message.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msgCode <= '0;
         msgText <= '0;
         msgPush <= 1'h0;
      end else begin
         msgPush <= fire;
         msgCode <= fire ? fireCode : ~msgCode;
         msgText <= fire ? fireCode + 16'h0004 : ~msgText;
      end
   end
endmodule
`default_nettype wire

// ---- verification/status_event_and_error_queue_test.sv ----
// Self-checking bench of the status block: register port tasks and test sequence.
`default_nettype none
module status_event_and_error_queue_test
   import status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, wrStb, rdStb, msgPush, irq, fire;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0] wrData, rdData, condMeas, condOper, condQues;
   logic [CODE_W-1:0] msgCode, fireCode;
   logic [MSG_W-1:0] msgText;
   logic [NGRP-1:0] summary;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   // The value twelve in decimal, hex, octal and binary notation.
   logic [REG_W-1:0] rep [4] = '{16'h0012, 16'h000C, 16'h0014, 16'h000C};
   status_event_and_error_queue dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .condMeas(condMeas),
      .condOper(condOper), .condQues(condQues), .msgCode(msgCode), .msgText(msgText),
      .msgPush(msgPush), .summary(summary), .irq(irq));
   msg_source src (.clk(clk), .rst(rst), .fire(fire), .fireCode(fireCode),
      .msgCode(msgCode), .msgText(msgText), .msgPush(msgPush));
   // Free-running 25 MHz clock.
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // Hang guard, well above the fewer than two hundred cycles the tests need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Waits settle one nanosecond past the edge so registered outputs have landed.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'h1;
      @(posedge clk);
      wrStb <= 1'h0;
   endtask
   // The answer stands only in the cycle after the strobe, so it is sampled there.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'h1;
      @(posedge clk);
      rdStb <= 1'h0;
      #1 chk(rdData, e);
   endtask
   task automatic push(input logic [CODE_W-1:0] c);
      @(posedge clk);
      fire <= 1'h1;
      fireCode <= c;
      @(posedge clk);
      fire <= 1'h0;
      cyc(4);
   endtask
   initial begin
      {rst, wrStb, rdStb, fire} = 4'h8;
      {addr, wrData, fireCode, condMeas, condOper, condQues} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      wr(ADR_IRQ_EN, 16'h0008);
      push(16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd(ADR_IRQ_STAT, 16'h0008);
      wr(ADR_IRQ_EN, 16'h0000);
      cyc(2);
      chk({15'h0, irq}, 16'h0000);
      wr(ADR_IRQ_EN, 16'h0008);
      cyc(2);
      chk({15'h0, irq}, 16'h0001);
      wr(ADR_IRQ_CLR, 16'h0008);
      cyc(2);
      chk({15'h0, irq}, 16'h0000);
      rd(ADR_IRQ_STAT, 16'h0000);
      $display("interrupt test done");
      wr(ADR_FILTER, 16'h00FB);
      push(16'h0002);
      push(16'h0003);
      rd(ADR_QCOUNT, 16'h0002);
      rd(ADR_QCOUNT, 16'h0002);
      rd(ADR_QNEXT, 16'h0001);
      rd(ADR_QMSG, 16'h0005);
      rd(ADR_QCOUNT, 16'h0001);
      rd(ADR_QALL, 16'h0003);
      rd(ADR_QCOUNT, 16'h0000);
      push(16'h0001);
      push(16'h0003);
      wr(ADR_CMD, 16'h0001 << CMD_QCLEAR);
      rd(ADR_QCOUNT, 16'h0000);
      $display("queue test done");
      for (int i = 0; i < 4; i++) begin
         wr(ADR_NUMFMT, REG_W'(i));
         wr(ADDR_W'(4 * (i % 3) + 1), rep[i]);
         wr(ADR_FORMAT, REG_W'((i + 1) % 4));
         rd(ADDR_W'(4 * (i % 3) + 1), rep[(i + 1) % 4]);
      end
      wr(ADR_NUMFMT, 16'h0000);
      $display("format test done");
      wr(6'h01, 16'h0001);
      condMeas <= 16'h0001;
      cyc(5);
      chk({13'h0, summary}, 16'h0001);
      condMeas <= 16'h0000;
      condOper <= 16'h0003;
      condQues <= 16'h0001;
      cyc(5);
      rd(6'h00, 16'h0001);
      rd(6'h02, 16'h0000);
      rd(6'h06, 16'h0003);
      rd(6'h0A, 16'h0001);
      chk({13'h0, summary}, 16'h0001);
      condOper <= 16'h0000;
      condQues <= 16'h0000;
      push(16'h0001);
      wr(ADR_CMD, 16'h000C);
      rd(6'h01, 16'h0001);
      rd(6'h04, 16'h0003);
      rd(ADR_QCOUNT, 16'h0001);
      wr(ADR_CMD, 16'h0001 << CMD_STPRESET);
      rd(6'h01, 16'h0000);
      rd(6'h00, 16'h0001);
      rd(ADR_QCOUNT, 16'h0001);
      chk({13'h0, summary}, 16'h0000);
      wr(6'h05, 16'h0002);
      wr(ADR_CMD, 16'h0001 << CMD_CLS);
      rd(ADR_QCOUNT, 16'h0000);
      rd(6'h04, 16'h0000);
      rd(6'h05, 16'h0002);
      $display("preset test done");
      wr(6'h3F, 16'h1234);
      rd(6'h3F, 16'h0000);
      rd(6'h03, 16'h0000);
      end_of_test();
   end
endmodule
bind status_event_and_error_queue status_checker watch (.clk(clk), .rst(rst), .addr(addr),
   .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .summary(summary),
   .irq(irq));
`default_nettype wire
